// >>> hdl/ntl_consts.svh
// constants of the narrowband transparent link block
`ifndef NTL_CONSTS_SVH
`define NTL_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define NTL_A_CTRL 8'h00
`define NTL_A_PRESET 8'h04
`define NTL_A_CFG 8'h08
`define NTL_A_IVL 8'h0c
`define NTL_A_CSLEN 8'h10
`define NTL_A_STAT 8'h14
`define NTL_A_PLIST 8'h18
`define NTL_TEXT_SEL 2'b01

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define NTL_CTRL_ONLINE 0
`define NTL_ST_ONLINE 0
`define NTL_ST_ID 1
`define NTL_ST_TXSEEN 2
`define NTL_ST_DROP 3
`define NTL_ST_CNT 8
`define NTL_CFG_RST 12'h250
`define NTL_IVL_RST 8'h0a
`define NTL_PRESET_FIRST 8'h33
`define NTL_PRESET_LAST 8'h45
`define NTL_PLIST_MASK 32'h0007ffff
`define NTL_EMPTY_TXT 40'h456d707479
`define NTL_CS_MAX 16

// ----------------------------------------------------------------
// timing and structure
// ----------------------------------------------------------------
`define NTL_CLK_PERIOD_NS 10
`define NTL_SEC_NS 1000000000
`define NTL_SEC_CYCLES (`NTL_SEC_NS / `NTL_CLK_PERIOD_NS)
`define NTL_MINUTE_S 60
`define NTL_FIRST_ID_MIN 8'h01
`define NTL_BLOCK_LEN 16
`define NTL_FIFO_DEPTH 16
`define NTL_CRC_POLY 16'h1021

`endif

// >>> hdl/ntl_pkg.sv
// types and shared arithmetic of the narrowband transparent link block
package ntl_pkg;

  typedef enum logic [2:0] {
    NTL_TX_IDLE,
    NTL_TX_DATA,
    NTL_TX_CRC_HI,
    NTL_TX_CRC_LO,
    NTL_TX_ID
  } ntl_tx_state_t;

  typedef struct packed {
    logic fec;
    logic modsel;
    logic [1:0] bw;
    logic [3:0] rate;
    logic [3:0] proto;
  } ntl_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_crc;
    logic is_id;
    logic last;
  } ntl_tx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic is_crc;
    logic eob;
  } ntl_rx_byte_t;

  // msb-first crc step; appending the crc high byte first gives zero
  function automatic logic [15:0] ntl_crc_step(logic [15:0] crc,
                                               logic [7:0] d,
                                               logic [15:0] poly);
    logic [15:0] c;
    c = crc ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction

endpackage

// >>> hdl/ntl_crc.sv
// per-block crc accumulator
`timescale 1ns/100ps
module ntl_crc #(
  parameter logic [15:0] POLY = 16'h1021
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic en,
  input wire logic start,
  input wire logic [7:0] d,
  output logic [15:0] crc
);
  logic [15:0] crc_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_reg <= 16'h0000;
    end else if (clr) begin
      crc_reg <= 16'h0000;
    end else if (en) begin
      // start restarts the block with this byte as its first
      crc_reg <= ntl_pkg::ntl_crc_step(start ? 16'h0000 : crc_reg, d,
                                       POLY);
    end
  end

  assign crc = crc_reg;
endmodule

// >>> hdl/ntl_link.sv
// transparent link framer with station identification scheduling
//
// Functional notes
// R1: no radio receive during identification
// R2: buffer host bytes during identification
// R3: identification length follows call sign text
// R4: text empty by default, reads Empty
// R5: identify one minute after going online
// R6: reidentify each interval with transmit activity
// R7: no identification if empty or idle
// R8: preset overwrites all configuration settings
// R9: each preset selects full link parameters
// R10: report list of supported presets
// R11: start packet at first serial byte
// R12: no master or slave roles
// R13: every received packet accepted, broadcast
// R14: forward received bytes immediately, one each
// R15: packets split into crc protected blocks
// R16: crc failure stops rest of packet
// R17: host writes go online command
// R18: block, polynomial, buffer depth are parameters
// R19: interval restarts, counts only with activity
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "ntl_consts.svh"
module ntl_link #(
  parameter int SEC_CYCLES = `NTL_SEC_CYCLES,
  parameter int MIN_SECONDS = `NTL_MINUTE_S,
  parameter int BLOCK_LEN = `NTL_BLOCK_LEN, // R18
  parameter int FIFO_DEPTH = `NTL_FIFO_DEPTH, // R18
  parameter logic [15:0] CRC_POLY = `NTL_CRC_POLY // R18
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hs_in_valid,
  input wire logic [7:0] hs_in_data,
  output logic hs_in_ready,
  output logic hs_out_valid,
  output logic [7:0] hs_out_data,
  output logic rf_tx_valid,
  output ntl_pkg::ntl_tx_byte_t rf_tx,
  input wire logic rf_tx_ready,
  input wire logic rf_rx_valid,
  input wire ntl_pkg::ntl_rx_byte_t rf_rx,
  output logic online,
  output logic id_active
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [39:0] EMPTY_TXT = `NTL_EMPTY_TXT;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic ntl_pkg::ntl_cfg_t preset_cfg(logic [7:0] n);
    case (n)
      8'h33: return `NTL_CFG_RST;
      8'h34: return 12'h251;
      8'h35: return 12'ha52;
      8'h36: return 12'h253;
      8'h37: return 12'h254;
      8'h38: return 12'h255;
      8'h39: return 12'h256;
      8'h3a: return 12'h557;
      8'h3b: return 12'h677;
      8'h3c: return 12'h558;
      8'h3d: return 12'h678;
      8'h3e: return 12'h932;
      8'h3f: return 12'h139;
      8'h40: return 12'hd5a;
      8'h41: return 12'he7a;
      8'h42: return 12'hd5b;
      8'h43: return 12'he7b;
      8'h44: return 12'hd5c;
      8'h45: return 12'he7c;
      default: return `NTL_CFG_RST;
    endcase
  endfunction

  // narrower channels carry fewer link rates
  function automatic logic cfg_ok(ntl_pkg::ntl_cfg_t c);
    case (c.bw)
      2'd0: return c.rate <= 4'd2;
      2'd1: return c.rate <= 4'd5;
      2'd2: return c.rate <= 4'd8;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ----------------------------------------------------------------
  logic ap, wr_pend_reg, is_pre, pre_in;
  logic [7:0] wa_reg;
  logic [31:0] hrdata_reg, rd_val;
  logic [3:0] ridx, widx;
  ntl_pkg::ntl_cfg_t cfg_reg;
  logic [7:0] ivl_reg, preset_reg, cs_mem [`NTL_CS_MAX];
  logic [4:0] cs_len_reg;
  logic online_reg, go_online, drop_reg, tx_seen_reg, id_req_reg;
  logic [AW:0] cnt_reg;
  ntl_pkg::ntl_tx_state_t tx_st_reg;

  assign ap = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0);
  assign ridx = haddr[5:2];
  assign widx = wa_reg[5:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ap & hwrite;
      wa_reg <= haddr[7:0];
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (haddr[7:6] == `NTL_TEXT_SEL) begin
      if (cs_len_reg == 5'd0) begin
        if (ridx < 4'd5)
          rd_val = {24'h0, EMPTY_TXT[8*(4-int'(ridx)) +: 8]}; // R4
      end else if ({1'b0, ridx} < cs_len_reg) begin
        rd_val = {24'h0, cs_mem[ridx]};
      end
    end else begin
      case (haddr[7:0])
        `NTL_A_CTRL: rd_val = {31'h0, online_reg};
        `NTL_A_PRESET: rd_val = {24'h0, preset_reg};
        `NTL_A_CFG: rd_val = {20'h0, cfg_reg};
        `NTL_A_IVL: rd_val = {24'h0, ivl_reg};
        `NTL_A_CSLEN: rd_val = {27'h0, cs_len_reg};
        `NTL_A_STAT: begin
          rd_val[`NTL_ST_ONLINE] = online_reg;
          rd_val[`NTL_ST_ID] = id_active;
          rd_val[`NTL_ST_TXSEEN] = tx_seen_reg;
          rd_val[`NTL_ST_DROP] = drop_reg;
          rd_val[`NTL_ST_CNT +: AW+1] = cnt_reg;
        end
        `NTL_A_PLIST: rd_val = `NTL_PLIST_MASK; // R10
        default: rd_val = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata_reg <= 32'h0;
    else if (ap & ~hwrite)
      hrdata_reg <= rd_val;
  end

  // ----------------------------------------------------------------
  // configuration settings
  // ----------------------------------------------------------------
  assign is_pre = wr_pend_reg & (wa_reg == `NTL_A_PRESET);
  assign pre_in = (hwdata[7:0] >= `NTL_PRESET_FIRST) &
                  (hwdata[7:0] <= `NTL_PRESET_LAST) & (hwdata[31:8] == 24'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= `NTL_CFG_RST;
      ivl_reg <= `NTL_IVL_RST;
      preset_reg <= `NTL_PRESET_FIRST;
      cs_len_reg <= 5'd0; // R4
    end else if (is_pre & pre_in) begin
      cfg_reg <= preset_cfg(hwdata[7:0]); // R8 R9
      ivl_reg <= `NTL_IVL_RST; // R8
      cs_len_reg <= 5'd0; // R8
      preset_reg <= hwdata[7:0];
    end else if (wr_pend_reg) begin
      case (wa_reg)
        `NTL_A_CFG: cfg_reg <= hwdata[11:0];
        `NTL_A_IVL: ivl_reg <= hwdata[7:0];
        `NTL_A_CSLEN: cs_len_reg <= (hwdata[7:0] > 8'(`NTL_CS_MAX)) ?
                                    5'(`NTL_CS_MAX) : hwdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_pend_reg && wa_reg[7:6] == `NTL_TEXT_SEL)
      cs_mem[widx] <= hwdata[7:0];
  end

  // one role for every unit: no address filter, no master setting
  assign go_online = wr_pend_reg & (wa_reg == `NTL_A_CTRL) &
                     hwdata[`NTL_CTRL_ONLINE] & ~online_reg & cfg_ok(cfg_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      online_reg <= 1'b0;
    else if (go_online)
      online_reg <= 1'b1; // R17
    else if (wr_pend_reg && wa_reg == `NTL_A_CTRL &&
             !hwdata[`NTL_CTRL_ONLINE])
      online_reg <= 1'b0;
  end
  assign online = online_reg;

  // ----------------------------------------------------------------
  // identification scheduler
  // ----------------------------------------------------------------
  logic [31:0] cyc_reg;
  logic [7:0] sec_reg, min_cnt_reg, min_nxt;
  logic first_reg, act_reg, run, tick, expire, restart, data_go, id_go;

  assign run = first_reg | act_reg;
  assign tick = run & (cyc_reg == 32'(SEC_CYCLES - 1)) &
                (sec_reg == 8'(MIN_SECONDS - 1));
  assign min_nxt = min_cnt_reg + 8'h01;
  assign expire = tick & (first_reg ? (min_nxt == `NTL_FIRST_ID_MIN) :
                  (ivl_reg != 8'h00) & (min_nxt >= ivl_reg)); // R5 R6
  assign restart = go_online | expire | (data_go & ~run);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_reg <= 32'h0;
      sec_reg <= 8'h00;
      min_cnt_reg <= 8'h00;
    end else if (restart || !run) begin
      cyc_reg <= 32'h0; // R19
      sec_reg <= 8'h00;
      min_cnt_reg <= 8'h00;
    end else if (cyc_reg != 32'(SEC_CYCLES - 1)) begin
      cyc_reg <= cyc_reg + 32'h1;
    end else begin
      cyc_reg <= 32'h0;
      sec_reg <= (sec_reg == 8'(MIN_SECONDS - 1)) ? 8'h00 :
                 sec_reg + 8'h01;
      if (tick)
        min_cnt_reg <= min_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_reg <= 1'b0;
      act_reg <= 1'b0;
      tx_seen_reg <= 1'b0;
      id_req_reg <= 1'b0;
    end else begin
      if (go_online)
        first_reg <= 1'b1;
      else if (expire)
        first_reg <= 1'b0;
      // activity arriving with the expiry opens the next interval
      if (data_go)
        act_reg <= 1'b1; // R19
      else if (expire)
        act_reg <= 1'b0;
      if (data_go)
        tx_seen_reg <= 1'b1;
      if (expire && cs_len_reg != 5'd0 && tx_seen_reg)
        id_req_reg <= 1'b1; // R7
      else if (id_go)
        id_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // host byte buffer, fills while identification is on the air
  // ----------------------------------------------------------------
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic push, pop;

  assign hs_in_ready = cnt_reg != (AW+1)'(FIFO_DEPTH); // R2
  assign push = hs_in_valid & hs_in_ready;

  always_ff @(posedge hclk) begin
    if (push)
      fifo_mem[wp_reg] <= hs_in_data; // R2
  end

  // depth must be a power of two: pointers wrap by overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ----------------------------------------------------------------
  // transmit framer
  // ----------------------------------------------------------------
  logic adv, tx_v_reg, more;
  ntl_pkg::ntl_tx_byte_t tx_reg;
  logic [15:0] blk_reg, tx_crc;
  logic [4:0] id_idx_reg;

  assign adv = ~tx_v_reg | rf_tx_ready;
  assign more = cnt_reg != '0;
  assign id_go = adv & (tx_st_reg == ntl_pkg::NTL_TX_IDLE) & id_req_reg &
                 (cs_len_reg != 5'd0);
  assign data_go = adv & more & ((tx_st_reg == ntl_pkg::NTL_TX_IDLE &&
                   !id_go && online_reg) || (tx_st_reg ==
                   ntl_pkg::NTL_TX_DATA && blk_reg < 16'(BLOCK_LEN)));
  assign pop = data_go;
  assign id_active = tx_st_reg == ntl_pkg::NTL_TX_ID;

  ntl_crc #(.POLY(CRC_POLY)) u_tx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(adv & (tx_st_reg == ntl_pkg::NTL_TX_CRC_LO)),
    .en(data_go),
    .start(1'b0),
    .d(fifo_mem[rp_reg]),
    .crc(tx_crc)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_reg <= ntl_pkg::NTL_TX_IDLE;
      tx_v_reg <= 1'b0;
      tx_reg <= '0;
      blk_reg <= 16'h0;
      id_idx_reg <= 5'd0;
    end else if (adv) begin
      tx_v_reg <= 1'b0;
      case (tx_st_reg)
        ntl_pkg::NTL_TX_IDLE: begin
          if (id_go) begin
            tx_st_reg <= ntl_pkg::NTL_TX_ID;
            id_idx_reg <= 5'd0;
          end else if (data_go) begin
            tx_v_reg <= 1'b1; // R11
            tx_reg <= {fifo_mem[rp_reg], 3'b000};
            blk_reg <= 16'h1;
            tx_st_reg <= ntl_pkg::NTL_TX_DATA;
          end
        end
        ntl_pkg::NTL_TX_DATA: begin
          tx_v_reg <= 1'b1;
          if (data_go) begin
            tx_reg <= {fifo_mem[rp_reg], 3'b000};
            blk_reg <= blk_reg + 16'h1;
          end else begin
            tx_reg <= {tx_crc[15:8], 3'b100}; // R15
            tx_st_reg <= ntl_pkg::NTL_TX_CRC_HI;
          end
        end
        ntl_pkg::NTL_TX_CRC_HI: begin
          tx_v_reg <= 1'b1;
          // pending identification or a dry buffer closes the packet
          tx_reg <= {tx_crc[7:0], 2'b10, ~more | id_req_reg}; // R15
          tx_st_reg <= ntl_pkg::NTL_TX_CRC_LO;
        end
        ntl_pkg::NTL_TX_CRC_LO: begin
          blk_reg <= 16'h0;
          tx_st_reg <= (tx_reg.last) ? ntl_pkg::NTL_TX_IDLE :
                       ntl_pkg::NTL_TX_DATA;
        end
        ntl_pkg::NTL_TX_ID: begin
          if (id_idx_reg == cs_len_reg) begin
            tx_st_reg <= ntl_pkg::NTL_TX_IDLE;
          end else begin
            tx_v_reg <= 1'b1; // R3
            tx_reg <= {cs_mem[id_idx_reg[3:0]], 2'b01,
                       id_idx_reg == cs_len_reg - 5'd1};
            id_idx_reg <= id_idx_reg + 5'd1;
          end
        end
        default: tx_st_reg <= ntl_pkg::NTL_TX_IDLE;
      endcase
    end
  end
  assign rf_tx_valid = tx_v_reg;
  assign rf_tx = tx_reg;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic take, bad, fwd, out_v_reg;
  logic [7:0] out_d_reg;
  logic [15:0] rx_crc;

  assign take = rf_rx_valid & online_reg & ~id_active; // R1 R12 R13
  assign bad = ntl_pkg::ntl_crc_step(rx_crc, rf_rx.data, CRC_POLY) !=
               16'h0;
  assign fwd = take & ~rf_rx.is_crc & (rf_rx.sop | ~drop_reg); // R16

  ntl_crc #(.POLY(CRC_POLY)) u_rx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(take & rf_rx.eob),
    .en(take & ~rf_rx.eob),
    .start(rf_rx.sop),
    .d(rf_rx.data),
    .crc(rx_crc)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      drop_reg <= 1'b0;
    else if (take & rf_rx.sop)
      drop_reg <= 1'b0;
    else if ((take & rf_rx.eob & bad) | (rf_rx_valid & id_active))
      drop_reg <= 1'b1; // R16 R1
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_v_reg <= 1'b0;
      out_d_reg <= 8'h00;
    end else begin
      out_v_reg <= fwd; // R14
      if (fwd)
        out_d_reg <= rf_rx.data;
    end
  end
  assign hs_out_valid = out_v_reg;
  assign hs_out_data = out_d_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rx_block;
    id_active |=> !hs_out_valid;
  endproperty
  a_rx_block: assert property (p_rx_block) // R1
    else $error("radio data delivered during identification");

  property p_buffer;
    id_active && push |=> cnt_reg == $past(cnt_reg) + 1'b1;
  endproperty
  a_buffer: assert property (p_buffer) // R2
    else $error("host byte lost during identification");

  property p_id_len;
    id_go ##1 (id_active && adv) [*2] |-> tx_reg.is_id;
  endproperty
  a_id_len: assert property (p_id_len) // R3
    else $error("identification byte not sent from text");

  property p_empty;
    ap && !hwrite && haddr[7:0] == 8'h40 && cs_len_reg == 5'd0
      |=> hrdata == 32'h45;
  endproperty
  a_empty: assert property (p_empty) // R4
    else $error("empty call sign does not read as Empty");

  property p_first;
    first_reg && tick && cs_len_reg != 5'd0 && tx_seen_reg
      |=> id_req_reg;
  endproperty
  a_first: assert property (p_first) // R5
    else $error("no identification one minute after online");

  property p_ivl;
    !first_reg && act_reg && tick && min_nxt == ivl_reg &&
      cs_len_reg != 5'd0 && tx_seen_reg |=> id_req_reg ##[0:40] id_active;
  endproperty
  a_ivl: assert property (p_ivl) // R6 R19
    else $error("interval identification missing");

  property p_suppress;
    $rose(id_active) |-> cs_len_reg != 5'd0 && tx_seen_reg;
  endproperty
  a_suppress: assert property (p_suppress) // R7
    else $error("identification sent while suppressed");

  property p_preset;
    is_pre && pre_in && hwdata[7:0] == `NTL_PRESET_FIRST
      |=> cfg_reg == `NTL_CFG_RST && cs_len_reg == 5'd0;
  endproperty
  a_preset: assert property (p_preset) // R8 R9
    else $error("preset did not overwrite settings");

  property p_list;
    ap && !hwrite && haddr[7:0] == `NTL_A_PLIST
      |=> hrdata == `NTL_PLIST_MASK;
  endproperty
  a_list: assert property (p_list) // R10
    else $error("preset list wrong");

  property p_start;
    tx_st_reg == ntl_pkg::NTL_TX_IDLE && adv && online_reg && more &&
      !id_req_reg |=> rf_tx_valid && !rf_tx.is_crc && !rf_tx.is_id;
  endproperty
  a_start: assert property (p_start) // R11
    else $error("packet start delayed");

  property p_fwd;
    take && !rf_rx.is_crc && rf_rx.sop
      |=> hs_out_valid && hs_out_data == $past(rf_rx.data);
  endproperty
  a_fwd: assert property (p_fwd) // R14
    else $error("received byte not forwarded next cycle");

  property p_stop;
    drop_reg && !(rf_rx_valid && rf_rx.sop) |=> !hs_out_valid;
  endproperty
  a_stop: assert property (p_stop) // R16
    else $error("data forwarded after crc failure");

  property p_crc_pair;
    rf_tx_valid && rf_tx_ready && tx_st_reg == ntl_pkg::NTL_TX_CRC_HI
      |=> rf_tx_valid && rf_tx.is_crc;
  endproperty
  a_crc_pair: assert property (p_crc_pair) // R15
    else $error("block crc incomplete");

  c_id: cover property ($fell(id_active));
  c_drop: cover property ($rose(drop_reg));
  c_full: cover property (id_active && !hs_in_ready);
endmodule

// >>> verification/ntl_radio_peer.sv
// radio peer model: modulator sink and demodulator source
`timescale 1ns/100ps
module ntl_radio_peer (
  input wire logic hclk,
  input wire logic slow,
  input wire logic rf_tx_valid,
  input wire ntl_pkg::ntl_tx_byte_t rf_tx,
  output logic rf_tx_ready,
  output logic rf_rx_valid,
  output ntl_pkg::ntl_rx_byte_t rf_rx
);
  ntl_pkg::ntl_tx_byte_t q[$];
  logic tog = 1'b0;
  initial begin
    rf_rx_valid = 1'b0;
    rf_rx = '0;
  end
  // every unit is a plain peer, no role to configure
  always @(posedge hclk) begin
    tog <= ~tog;
    if (rf_tx_valid && rf_tx_ready)
      q.push_back(rf_tx);
  end
  // slow mode stalls every other cycle to stretch each byte
  assign rf_tx_ready = !slow || tog;
  task automatic rx_byte(input logic [7:0] d, input logic [2:0] f);
    @(posedge hclk);
    rf_rx_valid <= 1'b1;
    rf_rx <= {d, f};
    @(posedge hclk);
    rf_rx_valid <= 1'b0;
    // released lines must not repeat the last byte
    rf_rx <= ~{d, f};
  endtask
endmodule

// >>> verification/testbench.sv
// self-checking bench of the transparent link framer
`timescale 1ns/100ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hrdy, hresp, slow, rv;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic hs_in_valid, hs_in_ready, hs_out_valid, tv, trdy;
  logic [7:0] hs_in_data, hs_out_data;
  logic online, id_active;
  logic [15:0] c;
  ntl_pkg::ntl_tx_byte_t tx;
  ntl_pkg::ntl_rx_byte_t rx;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  localparam logic [31:0] ROWS [9][2] = '{'{32'h00, 32'h0},
    '{32'h04, 32'h33}, '{32'h08, 32'h250}, '{32'h0c, 32'ha},
    '{32'h10, 32'h0}, '{32'h18, 32'h7ffff}, '{32'h40, 32'h45},
    '{32'h44, 32'h6d}, '{32'h20, 32'h0}};
  always #5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  ntl_link #(.SEC_CYCLES(10), .MIN_SECONDS(10)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .hs_in_valid(hs_in_valid), .hs_in_data(hs_in_data),
    .hs_in_ready(hs_in_ready), .hs_out_valid(hs_out_valid),
    .hs_out_data(hs_out_data), .rf_tx_valid(tv), .rf_tx(tx),
    .rf_tx_ready(trdy), .rf_rx_valid(rv), .rf_rx(rx),
    .online(online), .id_active(id_active));
  ntl_radio_peer peer (.hclk(hclk), .slow(slow), .rf_tx_valid(tv),
    .rf_tx(tx), .rf_tx_ready(trdy), .rf_rx_valid(rv), .rf_rx(rx));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc1(input logic [7:0] d);
    logic [15:0] v;
    v = {d, 8'h00};
    for (int i = 0; i < 8; i++)
      v = v[15] ? ((v << 1) ^ 16'h1021) : (v << 1);
    return v;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic c8(input logic [7:0] g, e);
    chk({24'h0, g}, {24'h0, e});
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic hs_send(input logic [7:0] d);
    @(posedge hclk);
    hs_in_valid <= 1'b1;
    hs_in_data <= d;
    @(posedge hclk);
    while (hs_in_ready !== 1'b1) @(posedge hclk);
    hs_in_valid <= 1'b0;
    hs_in_data <= ~d;
  endtask
  task automatic rx_chk(input logic [7:0] d, input logic [2:0] f,
                        input logic e);
    peer.rx_byte(d, f);
    #1;
    chk({31'h0, hs_out_valid}, {31'h0, e});
    if (e)
      c8(hs_out_data, d);
  endtask
  task automatic wait_for(input int n, input logic idv);
    for (int k = 0; k < 300; k++)
      if (peer.q.size() < n || id_active !== idv) @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("counts compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, slow} = '0;
    {hs_in_valid, hs_in_data} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk({27'h0, hresp, online, id_active, hs_out_valid, tv}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      ahb(1'b0, ROWS[i][0], 32'h0, r);
      chk(r, ROWS[i][1]);
    end
    ahb(1'b1, 32'h04, 32'd62, r);
    ahb(1'b0, 32'h08, 32'h0, r);
    chk(r, 32'h932);
    ahb(1'b1, 32'h04, 32'd70, r);
    ahb(1'b0, 32'h04, 32'h0, r);
    chk(r, 32'd62);
    ahb(1'b1, 32'h04, 32'd51, r);
    ahb(1'b1, 32'h10, 32'h2, r);
    ahb(1'b1, 32'h40, 32'h41, r);
    ahb(1'b1, 32'h44, 32'h42, r);
    ahb(1'b1, 32'h0c, 32'h1, r);
    ahb(1'b1, 32'h00, 32'h1, r);
    t0 = cyc;
    $display("test registers done");
    hs_send(8'h3c);
    chk({31'h0, online}, 32'h1);
    wait_for(3, 1'b0);
    c = crc1(8'h3c);
    c8(peer.q[0].data, 8'h3c);
    c8(peer.q[1].data, c[15:8]);
    c8(peer.q[2].data, c[7:0]);
    c8({6'h0, peer.q[2].is_crc, peer.q[2].last}, 8'h03);
    $display("test transmit done");
    c = crc1(8'h11);
    rx_chk(8'h11, 3'b100, 1'b1);
    rx_chk(c[15:8] ^ 8'h01, 3'b010, 1'b0);
    rx_chk(c[7:0], 3'b011, 1'b0);
    rx_chk(8'h22, 3'b000, 1'b0);
    rx_chk(8'h33, 3'b100, 1'b1);
    $display("test receive done");
    slow <= 1'b1;
    peer.q.delete();
    wait_for(0, 1'b1);
    chk({31'h0, (cyc - t0) inside {[98:106]}}, 32'h1);
    // both land in the first cycles of identification, before it can end
    fork
      hs_send(8'h5a);
      rx_chk(8'h77, 3'b100, 1'b0);
    join
    wait_for(3, 1'b0);
    c8(peer.q[0].data, 8'h41);
    c8({6'h0, peer.q[1].is_id, peer.q[1].last}, 8'h03);
    c8(peer.q[1].data, 8'h42);
    c8({peer.q[2].data, peer.q[2].is_id}, {8'h5a, 1'b0});
    // one minute interval, opened by the byte just sent
    peer.q.delete();
    t0 = cyc;
    wait_for(0, 1'b1);
    chk({31'h0, (cyc - t0) inside {[97:105]}}, 32'h1);
    $display("test identification done");
    tally_and_finish();
  end
endmodule
